/* File: logic/conditional_short_branch_unit.sv */
// Execute stage for the two-byte conditional relative branch group of the core.
// Assumes opcode, displacement, PC and flags come from core logic on i_clk, so no synchronisers.
`include "branch_defines.svh"
`default_nettype none

// Function
// [RULE1] Signed greater: jump only when sign and zero flags are both clear.
// [RULE2] Unsigned higher: jump only when carry set and zero clear.
// [RULE3] Signed at most: jump when sign or zero flag is set.
// [RULE4] Signed below: jump when the sign flag is set.
// [RULE5] No carry out: jump when the carry flag is clear.
// [RULE6] Unequal: jump when the zero flag is clear.
// [RULE7] Unsigned not above: jump when carry clear or zero set.
// [RULE8] Residue clear: jump when the sticky flag is clear.
// [RULE9] No overflow: jump when the overflow flag is clear.
// [RULE10] Trap clear: jump when the overflow trap flag is clear.
// [RULE11] Residue set: jump when the sticky flag is set.
// [RULE12] Taken target is next-instruction PC plus sign-extended displacement.
// [RULE13] Software keeps targets within -128 to +127 bytes of the instruction end.
// [RULE14] Not taken leaves PC just past the branch, continuing sequentially.
// [RULE15] Two bytes each; four states when not taken, eight when taken.
// [RULE16] No branch of the group changes any status flag.
module conditional_short_branch_unit
   import branch_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire logic               i_start,
   input  wire branch_pkg::byte_t  i_opcode,
   input  wire branch_pkg::byte_t  i_disp,
   input  wire branch_pkg::addr_t  i_pc,
   input  wire logic               i_msb_flag,
   input  wire logic               i_all_clear_flag,
   input  wire logic               i_arith_out_bit,
   input  wire logic               i_range_exceeded_flag,
   input  wire logic               i_latched_ovf_trap,
   input  wire logic               i_shifted_out_one_flag,
   output logic                    o_busy,
   output logic                    o_done,
   output logic                    o_taken,
   output logic                    o_illegal,
   output branch_pkg::addr_t       o_new_pc,
   output branch_pkg::count_t      o_states,
   output logic                    o_flag_wr
);
   import branch_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   exec_state_t state_q;
   count_t      cnt_q;
   logic        busy_q;
   logic        done_q;
   logic        taken_q;
   logic        illegal_q;
   addr_t       new_pc_q;
   count_t      states_q;
   logic        flag_wr_q;
   logic        accept;
   logic        taken_c;
   logic        in_group_c;
   addr_t       seq_pc;
   addr_t       disp_ext;
   count_t      states_c;

   // ---------------------------------------------------------------
   // Condition evaluation
   // ---------------------------------------------------------------
   branch_cond_eval u_cond (
      .i_opcode              (i_opcode),
      .i_msb_flag            (i_msb_flag),
      .i_all_clear_flag      (i_all_clear_flag),
      .i_arith_out_bit       (i_arith_out_bit),
      .i_range_exceeded_flag (i_range_exceeded_flag),
      .i_latched_ovf_trap    (i_latched_ovf_trap),
      .i_shifted_out_one_flag(i_shifted_out_one_flag),
      .o_taken               (taken_c),
      .o_in_group            (in_group_c)
   );

   // ---------------------------------------------------------------
   // Target and state count
   // ---------------------------------------------------------------
   // A start while a branch is still running is ignored.
   assign accept   = i_start && (state_q == ST_IDLE);
   assign seq_pc   = i_pc + `BRANCH_BYTES; // [RULE14]
   assign disp_ext = {{8{i_disp[7]}}, i_disp}; // [RULE12]

   always_comb begin
      if (!in_group_c) begin
         states_c = `STATES_UNKNOWN_OP;
      end else if (taken_c) begin
         states_c = `STATES_TAKEN; // [RULE15]
      end else begin
         states_c = `STATES_NOT_TAKEN; // [RULE15]
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         cnt_q   <= `STATE_COUNT_ZERO;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (accept) begin
                  state_q <= ST_EXEC;
                  busy_q  <= 1'b1;
                  cnt_q   <= states_c - `STATE_COUNT_ONE; // [RULE15]
               end
            end
            ST_EXEC: begin
               if (cnt_q == `STATE_COUNT_ZERO) begin
                  state_q <= ST_IDLE;
                  busy_q  <= 1'b0;
                  done_q  <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - `STATE_COUNT_ONE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Result capture
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         taken_q   <= 1'b0;
         illegal_q <= 1'b0;
         new_pc_q  <= 16'h0000;
         states_q  <= `STATE_COUNT_ZERO;
      end else if (accept) begin
         taken_q   <= taken_c;
         illegal_q <= !in_group_c;
         states_q  <= states_c;
         if (taken_c) begin
            new_pc_q <= seq_pc + disp_ext; // [RULE12]
         end else begin
            new_pc_q <= seq_pc; // [RULE14]
         end
      end
   end

   // Flags are never written back by this group.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_wr_q <= 1'b0;
      end else begin
         flag_wr_q <= 1'b0; // [RULE16]
      end
   end

   assign o_busy    = busy_q;
   assign o_done    = done_q;
   assign o_taken   = taken_q;
   assign o_illegal = illegal_q;
   assign o_new_pc  = new_pc_q;
   assign o_states  = states_q;
   assign o_flag_wr = flag_wr_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_run_taken;
      (o_busy && !o_done) [*8] ##1 (o_done && !o_busy);
   endsequence

   sequence s_run_not_taken;
      (o_busy && !o_done) [*4] ##1 (o_done && !o_busy);
   endsequence

   a_taken_target: assert property (accept && in_group_c && taken_c |=> // [RULE12]
         o_new_pc == $past(i_pc) + `BRANCH_BYTES + {{8{$past(i_disp[7])}}, $past(i_disp)})
      else $error("taken branch target wrong");

   a_fall_target: assert property (accept && in_group_c && !taken_c |=> // [RULE14]
         o_new_pc == $past(i_pc) + `BRANCH_BYTES && !o_taken)
      else $error("fall-through PC wrong");

   a_taken_length: assert property (accept && in_group_c && taken_c |=> s_run_taken) // [RULE15]
      else $error("taken branch did not last eight states");

   a_fall_length: assert property (accept && in_group_c && !taken_c |=> s_run_not_taken) // [RULE15]
      else $error("untaken branch did not last four states");

   a_flags_untouched: assert property (o_busy || o_done |-> !o_flag_wr) // [RULE16]
      else $error("flag write during branch");

   a_greater_cond: assert property (accept && i_opcode == `OPC_SIGNED_GREATER |=> // [RULE1]
         o_taken == ($past(!i_msb_flag) && $past(!i_all_clear_flag)))
      else $error("signed greater decision wrong");

   a_higher_cond: assert property (accept && i_opcode == `OPC_UNSIGNED_HIGHER |=> // [RULE2]
         o_taken == ($past(i_arith_out_bit) && $past(!i_all_clear_flag)))
      else $error("unsigned higher decision wrong");

   a_at_most_cond: assert property (accept && i_opcode == `OPC_SIGNED_AT_MOST |=> // [RULE3]
         o_taken == ($past(i_msb_flag) || $past(i_all_clear_flag)))
      else $error("signed at most decision wrong");

   a_not_above_cond: assert property (accept && i_opcode == `OPC_UNSIGNED_NOT_ABOVE |=> // [RULE7]
         o_taken == ($past(!i_arith_out_bit) || $past(i_all_clear_flag)))
      else $error("unsigned not above decision wrong");

   a_residue_cond: assert property (accept && i_opcode == `OPC_RESIDUE_SET |=> // [RULE11]
         o_taken == $past(i_shifted_out_one_flag))
      else $error("residue set decision wrong");

   a_trap_cond: assert property (accept && i_opcode == `OPC_TRAP_FLAG_CLEAR |=> // [RULE10]
         o_taken == $past(!i_latched_ovf_trap))
      else $error("trap clear decision wrong");

   a_below_cond: assert property (accept && i_opcode == `OPC_SIGNED_BELOW |=> // [RULE4]
         o_taken == $past(i_msb_flag))
      else $error("signed below decision wrong");

   a_no_carry_cond: assert property (accept && i_opcode == `OPC_NO_CARRY_OUT |=> // [RULE5]
         o_taken == $past(!i_arith_out_bit))
      else $error("no carry decision wrong");

   a_unequal_cond: assert property (accept && i_opcode == `OPC_ON_UNEQUAL |=> // [RULE6]
         o_taken == $past(!i_all_clear_flag))
      else $error("unequal decision wrong");

   a_residue_clr_cond: assert property (accept && i_opcode == `OPC_RESIDUE_CLEAR |=> // [RULE8]
         o_taken == $past(!i_shifted_out_one_flag))
      else $error("residue clear decision wrong");

   a_no_ovf_cond: assert property (accept && i_opcode == `OPC_NO_OVERFLOW_FLAG |=> // [RULE9]
         o_taken == $past(!i_range_exceeded_flag))
      else $error("no overflow decision wrong");

   a_busy_ignores: assert property (o_busy && i_start |=> $stable(o_new_pc) && $stable(o_states))
      else $error("start accepted while busy");

endmodule

`default_nettype wire

/* File: logic/branch_defines.svh */
// Constants for the conditional short branch unit: opcodes, sizes and state counts.
// Assumes inclusion by bare name from logic that also imports branch_pkg.
`ifndef BRANCH_DEFINES_SVH
`define BRANCH_DEFINES_SVH

// ---------------------------------------------------------------
// Opcode bytes of the short conditional branch group
// ---------------------------------------------------------------
`define OPC_SIGNED_GREATER     8'hd2
`define OPC_UNSIGNED_HIGHER    8'hd9
`define OPC_SIGNED_AT_MOST     8'hda
`define OPC_SIGNED_BELOW       8'hde
`define OPC_NO_CARRY_OUT       8'hd3
`define OPC_ON_UNEQUAL         8'hd7
`define OPC_UNSIGNED_NOT_ABOVE 8'hd1
`define OPC_RESIDUE_CLEAR      8'hd0
`define OPC_NO_OVERFLOW_FLAG   8'hd5
`define OPC_TRAP_FLAG_CLEAR    8'hd4
`define OPC_RESIDUE_SET        8'hd8

// ---------------------------------------------------------------
// Instruction length and state counts
// ---------------------------------------------------------------
`define BRANCH_BYTES       16'h0002
`define STATES_NOT_TAKEN   4'h4
`define STATES_TAKEN       4'h8
`define STATES_UNKNOWN_OP  4'h1
`define STATE_COUNT_ONE    4'h1
`define STATE_COUNT_ZERO   4'h0

`endif

/* File: logic/branch_pkg.sv */
// Types shared by the conditional short branch unit and its condition evaluator.
// Assumes the core clock domain; holds no logic.
`default_nettype none

package branch_pkg;

   typedef logic [15:0] addr_t;
   typedef logic [7:0]  byte_t;
   typedef logic [3:0]  count_t;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_EXEC
   } exec_state_t;

endpackage

`default_nettype wire

/* File: logic/branch_cond_eval.sv */
// Condition evaluator for the short conditional branch group.
// Assumes opcode and flags are stable within the cycle; purely combinational.
`include "branch_defines.svh"
`default_nettype none

module branch_cond_eval
   import branch_pkg::*;
(
   input  wire branch_pkg::byte_t i_opcode,
   input  wire logic              i_msb_flag,
   input  wire logic              i_all_clear_flag,
   input  wire logic              i_arith_out_bit,
   input  wire logic              i_range_exceeded_flag,
   input  wire logic              i_latched_ovf_trap,
   input  wire logic              i_shifted_out_one_flag,
   output logic                   o_taken,
   output logic                   o_in_group
);

   // ---------------------------------------------------------------
   // Condition decode
   // ---------------------------------------------------------------
   always_comb begin
      o_in_group = 1'b1;
      o_taken    = 1'b0;
      case (i_opcode)
         `OPC_SIGNED_GREATER: begin
            o_taken = !i_msb_flag && !i_all_clear_flag; // [RULE1]
         end
         `OPC_UNSIGNED_HIGHER: begin
            o_taken = i_arith_out_bit && !i_all_clear_flag; // [RULE2]
         end
         `OPC_SIGNED_AT_MOST: begin
            o_taken = i_msb_flag || i_all_clear_flag; // [RULE3]
         end
         `OPC_SIGNED_BELOW: begin
            o_taken = i_msb_flag; // [RULE4]
         end
         `OPC_NO_CARRY_OUT: begin
            o_taken = !i_arith_out_bit; // [RULE5]
         end
         `OPC_ON_UNEQUAL: begin
            o_taken = !i_all_clear_flag; // [RULE6]
         end
         `OPC_UNSIGNED_NOT_ABOVE: begin
            o_taken = !i_arith_out_bit || i_all_clear_flag; // [RULE7]
         end
         `OPC_RESIDUE_CLEAR: begin
            o_taken = !i_shifted_out_one_flag; // [RULE8]
         end
         `OPC_NO_OVERFLOW_FLAG: begin
            o_taken = !i_range_exceeded_flag; // [RULE9]
         end
         `OPC_TRAP_FLAG_CLEAR: begin
            o_taken = !i_latched_ovf_trap; // [RULE10]
         end
         `OPC_RESIDUE_SET: begin
            o_taken = i_shifted_out_one_flag; // [RULE11]
         end
         default: begin
            o_in_group = 1'b0;
            o_taken    = 1'b0;
         end
      endcase
   end

endmodule

`default_nettype wire

/* File: verif/test_conditional_short_branch_unit.sv */
// Self-checking testbench for the conditional short branch unit.
// Assumes logic/ files are compiled first; the bench drives every port itself.
`include "branch_defines.svh"
`default_nettype none

module test_conditional_short_branch_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import branch_pkg::*;

   logic         i_clk;
   logic         i_rst;
   logic         i_start;
   byte_t        i_opcode;
   byte_t        i_disp;
   addr_t        i_pc;
   logic [5:0]   fl;
   logic         o_busy;
   logic         o_done;
   logic         o_taken;
   logic         o_illegal;
   addr_t        o_new_pc;
   count_t       o_states;
   logic         o_flag_wr;
   int           fails;
   int           checked;

   conditional_short_branch_unit u_conditional_short_branch_unit (
      .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_opcode(i_opcode), .i_disp(i_disp),
      .i_pc(i_pc), .i_msb_flag(fl[5]), .i_all_clear_flag(fl[4]), .i_arith_out_bit(fl[3]),
      .i_range_exceeded_flag(fl[2]), .i_latched_ovf_trap(fl[1]), .i_shifted_out_one_flag(fl[0]),
      .o_busy(o_busy), .o_done(o_done), .o_taken(o_taken), .o_illegal(o_illegal),
      .o_new_pc(o_new_pc), .o_states(o_states), .o_flag_wr(o_flag_wr));

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      if (fails == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Flag order: sign, zero, carry, overflow, trap, sticky.
   function automatic logic exp_taken(input byte_t op, input logic [5:0] f);
      case (op)
         `OPC_SIGNED_GREATER:     return !f[5] && !f[4];
         `OPC_UNSIGNED_HIGHER:    return f[3] && !f[4];
         `OPC_SIGNED_AT_MOST:     return f[5] || f[4];
         `OPC_SIGNED_BELOW:       return f[5];
         `OPC_NO_CARRY_OUT:       return !f[3];
         `OPC_ON_UNEQUAL:         return !f[4];
         `OPC_UNSIGNED_NOT_ABOVE: return !f[3] || f[4];
         `OPC_RESIDUE_CLEAR:      return !f[0];
         `OPC_NO_OVERFLOW_FLAG:   return !f[2];
         `OPC_TRAP_FLAG_CLEAR:    return !f[1];
         `OPC_RESIDUE_SET:        return f[0];
         default:                 return 1'b0;
      endcase
   endfunction

   // Issues one branch, flips flags after accept, optionally pokes a start while busy.
   task automatic run(input byte_t op, input byte_t d, input addr_t pc, input logic [5:0] f,
                      input bit now, input bit poke);
      logic   tk;
      logic   ill;
      addr_t  npc;
      count_t st;
      int     n;
      tk  = exp_taken(op, f);
      ill = (op[7:4] != 4'hd) || (op inside {8'hd6, 8'hdb, 8'hdc, 8'hdd, 8'hdf});
      st  = ill ? `STATES_UNKNOWN_OP : (tk ? `STATES_TAKEN : `STATES_NOT_TAKEN);
      npc = pc + `BRANCH_BYTES + (tk ? {{8{d[7]}}, d} : 16'h0000);
      if (!now) @(posedge i_clk);
      i_start  <= 1'b1;
      i_opcode <= op;
      i_disp   <= d;
      i_pc     <= pc;
      fl       <= f;
      @(posedge i_clk);
      i_start <= 1'b0;
      fl      <= ~f;
      #1;
      chk(o_taken, tk);
      chk(o_illegal, ill);
      chk(o_states, st);
      n = 1;
      while (o_done !== 1'b1) begin
         chk(o_busy, 1'b1);
         chk(o_flag_wr, 1'b0);
         if (n > 20) begin
            fails++;
            end_sim;
         end
         @(posedge i_clk);
         if (poke && n == 1) begin
            i_start  <= 1'b1;
            i_opcode <= 8'hdb;
            i_pc     <= 16'h5555;
         end
         if (n == 2) i_start <= 1'b0;
         #1;
         n++;
      end
      chk(16'(n), {12'h000, st} + 16'h0001);
      chk(o_busy, 1'b0);
      chk(o_new_pc, npc);
      chk(o_taken, tk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic scen_all_conditions;
      byte_t ops[16] = '{`OPC_SIGNED_GREATER, `OPC_UNSIGNED_HIGHER, `OPC_SIGNED_AT_MOST,
         `OPC_SIGNED_BELOW, `OPC_NO_CARRY_OUT, `OPC_ON_UNEQUAL, `OPC_UNSIGNED_NOT_ABOVE,
         `OPC_RESIDUE_CLEAR, `OPC_NO_OVERFLOW_FLAG, `OPC_TRAP_FLAG_CLEAR, `OPC_RESIDUE_SET,
         8'hdb, 8'hdc, 8'hdd, 8'hd6, 8'h00};
      for (int i = 0; i < 16; i++) begin
         for (int f = 0; f < 64; f++) begin
            run(ops[i], 8'h10, 16'h2000, f[5:0], 1'b0, 1'b0);
         end
      end
   endtask

   task scen_displacement;
      run(`OPC_RESIDUE_SET, 8'h80, 16'h0100, 6'h01, 1'b0, 1'b0);
      run(`OPC_RESIDUE_SET, 8'h7f, 16'hfff0, 6'h01, 1'b0, 1'b0);
      run(`OPC_RESIDUE_SET, 8'hff, 16'h0000, 6'h01, 1'b0, 1'b0);
      run(`OPC_RESIDUE_SET, 8'h80, 16'hfffe, 6'h00, 1'b0, 1'b0);
   endtask

   task scen_back_to_back;
      run(`OPC_SIGNED_GREATER, 8'hfe, 16'h1000, 6'h00, 1'b0, 1'b1);
      run(`OPC_SIGNED_BELOW, 8'h04, 16'h3000, 6'h20, 1'b1, 1'b0);
      run(`OPC_TRAP_FLAG_CLEAR, 8'h04, 16'h3002, 6'h02, 1'b1, 1'b0);
      run(8'hdd, 8'h04, 16'h3004, 6'h00, 1'b1, 1'b0);
   endtask

   task scen_mid_reset;
      @(posedge i_clk);
      i_start  <= 1'b1;
      i_opcode <= `OPC_RESIDUE_SET;
      fl       <= 6'h01;
      i_pc     <= 16'h4000;
      i_disp   <= 8'h20;
      @(posedge i_clk);
      i_start <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b1;
      #1;
      chk(o_busy, 1'b0);
      chk(o_done, 1'b0);
      chk(o_taken, 1'b0);
      chk(o_new_pc, 16'h0000);
      chk(o_states, 4'h0);
      @(posedge i_clk);
      i_rst <= 1'b0;
      run(`OPC_ON_UNEQUAL, 8'h20, 16'h4000, 6'h10, 1'b0, 1'b0);
   endtask

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   initial begin
      i_rst    = 1'b1;
      i_start  = 1'b0;
      i_opcode = 8'h00;
      i_disp   = 8'h00;
      i_pc     = 16'h0000;
      fl       = 6'h00;
      fails    = 0;
      checked  = 0;
      repeat (5) @(posedge i_clk);
      #1;
      chk(o_busy, 1'b0);
      chk(o_done, 1'b0);
      chk(o_illegal, 1'b0);
      chk(o_new_pc, 16'h0000);
      @(posedge i_clk);
      i_rst <= 1'b0;
      scen_all_conditions;
      scen_displacement;
      scen_back_to_back;
      scen_mid_reset;
      end_sim;
   end
endmodule

`default_nettype wire
